// *** common/hsi_map.svh ***
`ifndef HSI_MAP_SVH
`define HSI_MAP_SVH

// ----------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------
`define HSI_ADDR_HI 6'h2b
`define HSI_ADDR_W 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HSI_CLK_MHZ 25
`define HSI_SDA_DLY_NS 120
`define HSI_SDA_DLY_CYC ((`HSI_SDA_DLY_NS * `HSI_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Reset values and location map
// ----------------------------------------------------------------
`define HSI_PTR_RST 8'h00
`define HSI_LOC_VALID 256'h0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000_081f
`define HSI_FIFO_DEPTH 8
`define HSI_FIFO_WIDTH 16

`endif

// *** common/hsi_pkg.sv ***
`include "hsi_map.svh"

package hsi_pkg;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACK = 8'h04,
    ST_WDATA = 8'h08,
    ST_RDATA = 8'h10,
    ST_RACK = 8'h20,
    ST_SKIP = 8'h40
  } hsi_state_e;

  // ----------------------------------------------------------------
  // State of the target apart from the reset synchroniser and the written-byte buffer
  // ----------------------------------------------------------------
  typedef struct packed {
    hsi_state_e st;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic [`HSI_SDA_DLY_CYC-1:0] sda_dly;
    logic adr_m;
    logic adr_s;
    logic scl_p;
    logic sda_p;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic ack;
    logic rw;
    logic first;
    logic drv;
    logic busy;
  } hsi_state_s;

endpackage : hsi_pkg

// *** design/hsi_fifo.sv ***
`timescale 1ns/1ps

module hsi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Room for a word
  input wire logic [WIDTH-1:0] in_data_i, // Word to store
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Sink takes word
  output logic [WIDTH-1:0] out_data_o // Oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hsi_fifo_s;

  hsi_fifo_s q_r;
  hsi_fifo_s q_nxt;
  logic push;
  logic pop;

  assign in_ready_o = (q_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q_r.cnt != '0);
  assign out_data_o = q_r.mem[q_r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data_i;
      q_nxt.wp = (q_r.wp == AW'(DEPTH - 1)) ? '0 : q_r.wp + 1'b1;
    end
    if (pop) begin
      q_nxt.rp = (q_r.rp == AW'(DEPTH - 1)) ? '0 : q_r.rp + 1'b1;
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + 1'b1;
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= '0;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

endmodule : hsi_fifo

// *** design/hsi_target.sv ***
`timescale 1ns/1ps
`include "hsi_map.svh"

module hsi_target #(
  parameter logic [255:0] LOC_VALID = `HSI_LOC_VALID,
  parameter int FIFO_DEPTH = `HSI_FIFO_DEPTH
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic scl_i, // Bus clock pin level
  input wire logic sda_i, // Bus data pin level
  output logic sda_o, // Data pin drive value, always low
  output logic sda_oe_n_o, // Data pin enable, low while pulling
  input wire logic adr_sel_i, // Address strap pin
  output logic [7:0] rd_ptr_o, // Location being read
  input wire logic [7:0] rd_data_i, // Contents of rd_ptr_o
  output logic wr_valid_o, // Written byte available
  input wire logic wr_ready_i, // Sink takes written byte
  output logic [7:0] wr_ptr_o, // Location of written byte
  output logic [7:0] wr_data_o, // Written byte
  output logic busy_o // Addressed transfer in progress
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // Location map
  // ----------------------------------------------------------------
  function automatic logic loc_ok(input logic [7:0] loc);
    loc_ok = LOC_VALID[loc];
  endfunction : loc_ok

  // ----------------------------------------------------------------
  // State and bus events
  // ----------------------------------------------------------------
  hsi_pkg::hsi_state_s q_r;
  hsi_pkg::hsi_state_s q_nxt;
  logic sda_v;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic fifo_push;
  logic fifo_ready;
  logic [15:0] fifo_dout;

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Three extra samples on SDA hold it across a slow falling SCL
  assign sda_v = q_r.sda_dly[`HSI_SDA_DLY_CYC-1];
  // SCL high and low must each last three clocks; 1 MHz leaves ample room
  assign scl_rise = q_r.scl_s & ~q_r.scl_p;
  assign scl_fall = ~q_r.scl_s & q_r.scl_p;
  // SCL must be high on both samples so a late SDA edge never looks like START
  assign start_det = q_r.scl_s & q_r.scl_p & q_r.sda_p & ~sda_v;
  assign stop_det = q_r.scl_s & q_r.scl_p & ~q_r.sda_p & sda_v;
  assign byte_in = {q_r.sh[6:0], sda_v};
  assign rd_byte = loc_ok(q_r.ptr) ? rd_data_i : 8'h00;

  // ----------------------------------------------------------------
  // Write acceptance
  // ----------------------------------------------------------------
  logic bus_cond;
  logic wr_last_bit;
  logic wr_data_byte;
  logic wr_accept;

  // A START or STOP outranks any bit event seen in the same cycle
  assign bus_cond = start_det | stop_det;
  // Byte completes on the eighth rising edge of a write
  assign wr_last_bit = (q_r.st == hsi_pkg::ST_WDATA) && scl_rise && (q_r.cnt == 4'h7);
  // The pointer byte itself never reaches the buffer
  assign wr_data_byte = wr_last_bit && !q_r.first;
  // Invalid place or a full buffer both make a byte that cannot be taken
  assign wr_accept = loc_ok(q_r.ptr) && fifo_ready;
  assign fifo_push = wr_data_byte && wr_accept && !bus_cond;

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_m = scl_i;
    q_nxt.scl_s = q_r.scl_m;
    q_nxt.sda_m = sda_i;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.sda_dly = {q_r.sda_dly[`HSI_SDA_DLY_CYC-2:0], q_r.sda_s};
    q_nxt.adr_m = adr_sel_i;
    q_nxt.adr_s = q_r.adr_m;
    q_nxt.scl_p = q_r.scl_s;
    q_nxt.sda_p = sda_v;

    if (start_det) begin
      q_nxt.st = hsi_pkg::ST_ADDR;
      q_nxt.cnt = 4'h0;
      q_nxt.drv = 1'b0;
      q_nxt.busy = 1'b0;
    end else if (stop_det) begin
      q_nxt.st = hsi_pkg::ST_IDLE;
      q_nxt.cnt = 4'h0;
      q_nxt.drv = 1'b0;
      q_nxt.busy = 1'b0;
    end else begin
      unique case (q_r.st)
        hsi_pkg::ST_IDLE: begin
          q_nxt.drv = 1'b0;
        end
        hsi_pkg::ST_ADDR: begin
          if (scl_rise) begin
            q_nxt.sh = byte_in;
            q_nxt.cnt = q_r.cnt + 4'h1;
            if (q_r.cnt == 4'h7) begin
              // General call and 10-bit prefixes never equal this pattern
              q_nxt.ack = (byte_in[7:1] == {`HSI_ADDR_HI, q_r.adr_s});
              q_nxt.rw = byte_in[0];
            end
          end else if (scl_fall && q_r.cnt == 4'h8) begin
            q_nxt.cnt = 4'h0;
            if (q_r.ack) begin
              q_nxt.st = hsi_pkg::ST_ACK;
              q_nxt.drv = 1'b1;
              q_nxt.busy = 1'b1;
              // A write loads the pointer first; a read starts where it stands
              q_nxt.first = ~q_r.rw;
            end else begin
              q_nxt.st = hsi_pkg::ST_SKIP;
            end
          end
        end
        hsi_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (q_r.rw) begin
              // rd_data_i is taken here, so it must follow rd_ptr_o within the cycle
              q_nxt.st = hsi_pkg::ST_RDATA;
              q_nxt.drv = ~rd_byte[7];
              q_nxt.tx = {rd_byte[6:0], 1'b0};
              q_nxt.cnt = 4'h1;
            end else begin
              q_nxt.st = hsi_pkg::ST_WDATA;
              q_nxt.drv = 1'b0;
              q_nxt.cnt = 4'h0;
            end
          end
        end
        hsi_pkg::ST_WDATA: begin
          if (scl_rise) begin
            q_nxt.sh = byte_in;
            q_nxt.cnt = q_r.cnt + 4'h1;
            if (q_r.cnt == 4'h7) begin
              if (q_r.first) begin
                q_nxt.ptr = byte_in;
                q_nxt.ack = loc_ok(byte_in);
                q_nxt.first = 1'b0;
              end else begin
                q_nxt.ack = fifo_push;
                q_nxt.ptr = q_r.ptr + 8'h01;
              end
            end
          end else if (scl_fall && q_r.cnt == 4'h8) begin
            q_nxt.st = hsi_pkg::ST_ACK;
            q_nxt.drv = q_r.ack;
            q_nxt.cnt = 4'h0;
          end
        end
        hsi_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (q_r.cnt == 4'h8) begin
              q_nxt.st = hsi_pkg::ST_RACK;
              q_nxt.drv = 1'b0;
              q_nxt.ptr = q_r.ptr + 8'h01;
              q_nxt.ack = 1'b0;
            end else begin
              q_nxt.drv = ~q_r.tx[7];
              q_nxt.tx = {q_r.tx[6:0], 1'b0};
              q_nxt.cnt = q_r.cnt + 4'h1;
            end
          end
        end
        hsi_pkg::ST_RACK: begin
          if (scl_rise) begin
            // Controller ACK keeps the read going; NACK frees the line for STOP
            q_nxt.ack = ~sda_v;
          end else if (scl_fall) begin
            if (q_r.ack) begin
              q_nxt.st = hsi_pkg::ST_RDATA;
              q_nxt.drv = ~rd_byte[7];
              q_nxt.tx = {rd_byte[6:0], 1'b0};
              q_nxt.cnt = 4'h1;
            end else begin
              q_nxt.st = hsi_pkg::ST_SKIP;
              q_nxt.drv = 1'b0;
              q_nxt.busy = 1'b0;
            end
          end
        end
        hsi_pkg::ST_SKIP: begin
          q_nxt.drv = 1'b0;
        end
        default: begin
          q_nxt.st = hsi_pkg::ST_IDLE;
          q_nxt.drv = 1'b0;
          q_nxt.busy = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      // Pipelines start at the idle bus level so reset makes no false edge
      q_r.st <= hsi_pkg::ST_IDLE;
      q_r.scl_m <= 1'b1;
      q_r.scl_s <= 1'b1;
      q_r.sda_m <= 1'b1;
      q_r.sda_s <= 1'b1;
      q_r.sda_dly <= '1;
      q_r.scl_p <= 1'b1;
      q_r.sda_p <= 1'b1;
      q_r.ptr <= `HSI_PTR_RST;
    end else if (ce_i) begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Written-byte buffer
  // ----------------------------------------------------------------
  hsi_fifo #(
    .WIDTH(`HSI_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_ready),
    .in_data_i({q_r.ptr, byte_in}),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_dout)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pull-down only; SCL has no driver at all
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~q_r.drv;
  // Pointer output comes straight from a flip-flop; buffer outputs pass through the FIFO read mux
  assign rd_ptr_o = q_r.ptr;
  assign wr_ptr_o = fifo_dout[15:8];
  assign wr_data_o = fifo_dout[7:0];
  assign busy_o = q_r.busy;

endmodule : hsi_target

// *** sim/hsi_target_checker.sv ***
`timescale 1ns/1ps
`include "hsi_map.svh"

module hsi_target_checker #(
  parameter logic [255:0] LOC_VALID = `HSI_LOC_VALID
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Data wire
  input wire logic sda_o, // Drive value
  input wire logic sda_oe_n_o, // Drive enable
  input wire logic [7:0] rd_ptr_o, // Pointer
  input wire logic wr_valid_o, // Word ready
  input wire logic wr_ready_i, // Word taken
  input wire logic [7:0] wr_ptr_o, // Word place
  input wire logic [7:0] wr_data_o, // Word data
  input wire logic busy_o // Addressed
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sda_zero_a: assert property (sda_o == 1'b0)
    else $error("drive value not low");
  oe_scl_low_a: assert property (
    $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
    else $error("data drive moved with clock high");
  start_idle_a: assert property (
    $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:10] (!busy_o && sda_oe_n_o))
    else $error("start not taken");
  stop_idle_a: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:10] (!busy_o && sda_oe_n_o))
    else $error("stop not taken");
  ack_busy_a: assert property (!sda_oe_n_o |-> busy_o)
    else $error("data pulled low outside an addressed transfer");
  fifo_hold_a: assert property (
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_ptr_o, wr_data_o}))
    else $error("stalled word changed");
  wr_loc_a: assert property (wr_valid_o |-> LOC_VALID[wr_ptr_o])
    else $error("word for invalid place");
  wr_busy_a: assert property ($rose(wr_valid_o) |-> busy_o)
    else $error("word outside transfer");
  ptr_busy_a: assert property ($changed(rd_ptr_o) |-> busy_o || $past(busy_o))
    else $error("pointer moved outside transfer");
  cover property ($rose(wr_valid_o));
  cover property ($rose(busy_o));
  cover property (wr_valid_o && !wr_ready_i);
endmodule : hsi_target_checker

bind hsi_target hsi_target_checker #(.LOC_VALID(LOC_VALID)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .rd_ptr_o(rd_ptr_o), .wr_valid_o(wr_valid_o),
  .wr_ready_i(wr_ready_i), .wr_ptr_o(wr_ptr_o), .wr_data_o(wr_data_o), .busy_o(busy_o));

// *** sim/hsi_bus_master.sv ***
`timescale 1ns/1ps

module hsi_bus_master (
  output logic scl_o, // Bus clock
  output logic sda_oe_n_o, // Low while pulling data
  input wire logic sda_i // Data wire
);
  int q = 250;

  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // Bus cycles, q is a quarter clock period
  // ----------------------------------------------------------------
  task automatic bstart();
    #(q);
    sda_oe_n_o = 1'b1;
    #(q);
    scl_o = 1'b1;
    #(2 * q);
    sda_oe_n_o = 1'b0;
    #(2 * q);
    scl_o = 1'b0;
  endtask : bstart

  task automatic bstop();
    #(q);
    sda_oe_n_o = 1'b0;
    #(q);
    scl_o = 1'b1;
    #(2 * q);
    sda_oe_n_o = 1'b1;
    #(2 * q);
  endtask : bstop

  // Eight bits then the acknowledge slot, data moved only while clock is low
  task automatic bbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #(q);
      sda_oe_n_o = tx[i];
      #(q);
      scl_o = 1'b1;
      #(q);
      rx[i] = sda_i;
      #(q);
      scl_o = 1'b0;
    end
  endtask : bbyte
endmodule : hsi_bus_master

// *** sim/hall_sensor_i2c_target_test.sv ***
`timescale 1ns/1ps
`include "hsi_map.svh"

module hall_sensor_i2c_target_test;
  logic clk_i, rst_n_i, adr_sel_i, wr_ready_i, scl, m_oe_n, sda_oe_n, wr_valid, busy, hold;
  logic [7:0] rd_ptr, rd_data, wr_ptr, wr_data, p;
  logic [8:0] rx;
  logic [15:0] ew;
  logic [31:0] r, rr;
  logic [15:0] expq[$];
  logic [255:0] locs = `HSI_LOC_VALID;
  logic [6:0] alist[4] = '{7'h56, 7'h57, 7'h00, 7'h78};
  int sp[3] = '{2500, 625, 250};
  int fail_count = 0;
  int tests_run = 0;
  int seed = 49;
  int seed_r = 49;
  int cyc = 0;
  wire sda = m_oe_n & sda_oe_n;

  assign rd_data = rd_ptr ^ 8'ha5;

  hsi_target dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_n_o(sda_oe_n), .adr_sel_i(adr_sel_i), .rd_ptr_o(rd_ptr), .rd_data_i(rd_data),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i), .wr_ptr_o(wr_ptr), .wr_data_o(wr_data),
    .busy_o(busy));

  hsi_bus_master ctl (.scl_o(scl), .sda_oe_n_o(m_oe_n), .sda_i(sda));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [7:0] ev(input logic [7:0] a);
    return locs[a] ? (a ^ 8'ha5) : 8'h00;
  endfunction : ev

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [7:0] b, input logic ea);
    ctl.bbyte({b, 1'b1}, rx);
    chk("ack", 16'(!ea), 16'(rx[0]));
  endtask : wr

  task automatic wd(input logic [7:0] a, input logic [7:0] d, input logic ea);
    if (ea) begin
      expq.push_back({a, d});
    end
    wr(d, ea);
  endtask : wd

  task automatic ad(input logic rw);
    ctl.bstart();
    wr({`HSI_ADDR_HI, adr_sel_i, rw}, 1'b1);
  endtask : ad

  task automatic rd(input logic [7:0] a, input logic last);
    ctl.bbyte({8'hff, last}, rx);
    chk("read byte", 16'(ev(a)), 16'(rx[8:1]));
  endtask : rd

  task automatic drain();
    for (int n = 0; n < 300 && expq.size() > 0; n++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk("left in buffer", 16'h0000, 16'(expq.size()));
    chk("valid when empty", 16'h0000, 16'(wr_valid));
  endtask : drain

  // Buffer sink with random stalls, word check and hang limit
  always @(posedge clk_i) begin
    cyc++;
    rr = $random(seed_r);
    if (wr_valid && wr_ready_i) begin
      ew = expq.size() > 0 ? expq.pop_front() : 16'hxxxx;
      chk("buffer word", ew, {wr_ptr, wr_data});
    end
    wr_ready_i <= !hold && rr[0];
    if (cyc == 100000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    adr_sel_i = 1'b0;
    hold = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_i);
      adr_sel_i <= s[0];
      foreach (alist[i]) begin
        ctl.bstart();
        wr({alist[i], 1'b0}, alist[i] == {`HSI_ADDR_HI, s[0]});
        wr(8'h02, alist[i] == {`HSI_ADDR_HI, s[0]});
        chk("busy", 16'(alist[i] == {`HSI_ADDR_HI, s[0]}), 16'(busy));
        ctl.bstop();
      end
    end
    hold = 1'b1;
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      ad(1'b0);
      wr(8'h03, 1'b1);
      wd(8'h03, r[7:0], i < 8);
      ctl.bstop();
    end
    hold = 1'b0;
    drain();
    ad(1'b0);
    wr(8'h0a, 1'b0);
    wd(8'h0a, 8'h11, 1'b0);
    wd(8'h0b, 8'h22, 1'b1);
    wd(8'h0c, 8'h33, 1'b0);
    ad(1'b0);
    wr(8'hff, 1'b0);
    wd(8'hff, 8'h44, 1'b0);
    wd(8'h00, 8'h55, 1'b1);
    ad(1'b0);
    wr(8'hfe, 1'b0);
    ad(1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(8'hfe + 8'(i), i == 3);
    end
    #400;
    chk("released", 16'h0001, 16'(sda));
    chk("busy after nack", 16'h0000, 16'(busy));
    ctl.bstop();
    ad(1'b1);
    rd(8'h02, 1'b1);
    ctl.bstop();
    foreach (sp[k]) begin
      ctl.q = sp[k];
      for (int i = 0; i < 2; i++) begin
        r = $random(seed);
        p = {4'h0, r[3:0]};
        ad(1'b0);
        wr(p, locs[p]);
        wd(p, r[15:8], locs[p]);
        wd(p + 8'h01, r[23:16], locs[p + 8'h01]);
        ctl.bstop();
      end
    end
    drain();
    final_report();
  end
endmodule : hall_sensor_i2c_target_test
